// File: bench/sram_dev_model.sv
// Purpose: behavioural edac sram answering the host pins
// Assumes: pins change just after the clock edge
// Notes: flag pin has a pull-down, undriven reads low
`timescale 1ns/1ps
`default_nettype none
module sram_dev_model (
    input wire logic i_sys_clk,
    input wire logic i_cs_n,
    input wire logic i_cs,
    input wire logic i_we_n,
    input wire logic i_oe_n,
    input wire logic [18:0] i_addr,
    input wire logic [31:0] i_dq,
    input wire logic i_dq_oe,
    output logic [31:0] o_dq,
    output logic o_flag
);
    bit [32:0] mem [0:524287]; // top bit marks a written word
    logic err = 1'b0;
    logic armed = 1'b0;
    logic [31:0] last = 32'h00000000;
    wire logic sel = !i_cs_n && i_cs;
    wire logic rd = sel && i_we_n && !i_oe_n;
    wire logic scrub = !i_cs_n && !i_cs;
    wire logic hit = rd && !mem[i_addr][32];
    wire logic clr = rd && armed && mem[i_addr][32];
    // released data shows the inverse of the last word, never a stale copy
    assign o_dq = rd ? mem[i_addr][31:0] : ~last;
    // flag answers at once, so the host sees it well inside its valid delay
    assign o_flag = (rd || (scrub && !i_oe_n)) ?
        ((err || hit) && !clr) : 1'b0;
    // edac function access is not modelled: the host must never enter it
    always @(posedge i_sys_clk)
    begin
        if (sel && !i_we_n && i_dq_oe)
            mem[i_addr] <= {1'b1, i_dq};
        if (rd)
            last <= mem[i_addr][31:0];
        if (!sel && i_oe_n && err)
            armed <= 1'b1;
        if (hit)
            err <= 1'b1;
        else if (clr)
        begin
            err <= 1'b0;
            armed <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: bench/sram_host_ctrl_sva.sv
// Purpose: pin protocol checks for the sram host controller
// Assumes: one clock domain
// Notes: settle window sized for the short settle count
`timescale 1ns/1ps
`default_nettype none
module sram_host_ctrl_sva #(
    parameter int ADDR_W = 19
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic o_err,
    input wire logic [ADDR_W-1:0] o_err_addr,
    input wire logic [ADDR_W-1:0] o_addr,
    input wire logic o_chip_select_active_low,
    input wire logic o_chip_select_active_high,
    input wire logic o_write_strobe_n,
    input wire logic o_output_drive_enable_n,
    input wire logic o_dq_oe,
    input wire logic i_bit_error_flag
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    wire logic cs = o_chip_select_active_high;
    wire logic oe_n = o_output_drive_enable_n;
    wire logic we_n = o_write_strobe_n;
    wire logic sel = cs && !o_chip_select_active_low;
    // error entry and reselect with the outputs still off
    sequence s_err; $rose(o_err); endsequence
    sequence s_resel; $rose(cs) && oe_n && we_n; endsequence
    property p_desel_first; $rose(oe_n) |-> !sel; endproperty
    a_desel_first: assert property (p_desel_first) else $error("raised while selected");
    property p_edac_avoid; sel && oe_n && we_n |-> !i_bit_error_flag; endproperty
    a_edac_avoid: assert property (p_edac_avoid) else $error("function access entered");
    property p_write_drive; !we_n |-> o_dq_oe && sel; endproperty
    a_write_drive: assert property (p_write_drive) else $error("write without data");
    property p_read_quiet; sel && !oe_n |-> we_n && !o_dq_oe; endproperty
    a_read_quiet: assert property (p_read_quiet) else $error("bus fight on read");
    property p_settle; s_err |-> !cs [*3]; endproperty
    a_settle: assert property (p_settle) else $error("reselected too soon");
    property p_new_addr; s_err |=> o_addr != o_err_addr; endproperty
    a_new_addr: assert property (p_new_addr) else $error("address not moved");
    property p_record; s_err |-> o_err_addr == $past(o_addr); endproperty
    a_record: assert property (p_record) else $error("failing address lost");
    property p_resel_read; s_resel |=> !oe_n && we_n; endproperty
    a_resel_read: assert property (p_resel_read) else $error("no recovery read");
endmodule
bind sram_host_ctrl sram_host_ctrl_sva #(.ADDR_W(ADDR_W)) i_sram_host_ctrl_sva (.i_sys_clk,
    .i_rst_n, .o_err, .o_err_addr, .o_addr, .o_chip_select_active_low,
    .o_chip_select_active_high, .o_write_strobe_n, .o_output_drive_enable_n, .o_dq_oe,
    .i_bit_error_flag);
`default_nettype wire

// File: bench/testbench.sv
// Purpose: self-checking bench for the sram host controller
// Assumes: settle count cut to one cycle
// Notes: a watcher checks read answers against a queue of notes
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_req = 1'b0;
    logic i_we = 1'b0;
    logic i_err_ack = 1'b0;
    logic [18:0] i_addr = 19'h00000;
    logic [31:0] i_wdata = 32'h00000000;
    logic [31:0] i_dq, o_dq, o_rdata;
    logic [18:0] o_addr, o_err_addr;
    logic o_busy, o_rvalid, o_err, o_recovered, o_dq_oe, i_bit_error_flag;
    logic o_chip_select_active_low, o_chip_select_active_high;
    logic o_write_strobe_n, o_output_drive_enable_n;
    logic [31:0] notes[$];
    int err_total = 0;
    int comparisons = 0;
    int rec_seen = 0;
    always #5 i_sys_clk = ~i_sys_clk;
    sram_host_ctrl #(.SETTLE_CYC(1)) i_sram_host_ctrl (.i_sys_clk, .i_rst_n, .i_req, .i_we,
        .i_addr, .i_wdata, .i_err_ack, .o_busy, .o_rvalid, .o_rdata, .o_err, .o_err_addr,
        .o_recovered, .o_addr, .o_chip_select_active_low, .o_chip_select_active_high,
        .o_write_strobe_n, .o_output_drive_enable_n, .o_dq, .o_dq_oe, .i_dq, .i_bit_error_flag);
    sram_dev_model i_sram_dev_model (.i_sys_clk, .i_cs_n(o_chip_select_active_low),
        .i_cs(o_chip_select_active_high), .i_we_n(o_write_strobe_n),
        .i_oe_n(o_output_drive_enable_n), .i_addr(o_addr), .i_dq(o_dq), .i_dq_oe(o_dq_oe),
        .o_dq(i_dq), .o_flag(i_bit_error_flag));
    task automatic conclude();
        if (err_total == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one request, then wait for idle under a bound so a hang is counted
    task automatic op(input logic w, input logic [18:0] a, input logic [31:0] d);
        int n;
        n = 0;
        i_req <= 1'b1;
        i_we <= w;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_req <= 1'b0;
        do
            @(posedge i_sys_clk);
        while (o_busy && ++n < 60);
        if (n >= 60)
            err_total++;
    endtask
    // each read answer is matched with the oldest note while any note is queued
    always @(posedge i_sys_clk)
    begin
        if (o_rvalid && notes.size() > 0)
        begin
            `CHK(o_rdata, notes[0])
            void'(notes.pop_front());
        end
        if (o_recovered)
            rec_seen++;
    end
    initial
    begin
        logic [31:0] d[4];
        void'($urandom(91336));
        repeat (3) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        // fill four words, read them back in order, then four more reads of randomly picked words
        for (int k = 0; k < 4; k++)
        begin
            d[k] = $urandom;
            op(1'b1, 19'(k), d[k]);
        end
        for (int k = 0; k < 8; k++)
        begin
            int j;
            j = (k < 4) ? k : $urandom_range(3);
            notes.push_back(d[j]);
            op(1'b0, 19'(j), 32'h00000000);
        end
        `CHK(o_err, 1'b0)
        // an unwritten word raises the flag and starts the clearing run
        op(1'b0, 19'h00100, 32'h00000000);
        repeat (2) @(posedge i_sys_clk);
        `CHK(o_err, 1'b1)
        `CHK(o_err_addr, 19'h00100)
        `CHK(rec_seen, 1)
        i_err_ack <= 1'b1;
        @(posedge i_sys_clk);
        i_err_ack <= 1'b0;
        @(posedge i_sys_clk);
        `CHK(o_err, 1'b0)
        notes.push_back(d[2]);
        op(1'b0, 19'h00002, 32'h00000000);
        repeat (2) @(posedge i_sys_clk);
        `CHK(o_err, 1'b0)
        `CHK(notes.size(), 0)
        conclude();
    end
    initial
    begin
        #100000;
        err_total++;
        conclude();
    end
endmodule
`default_nettype wire

// File: design/cycle_timer.sv
// Purpose: down counter giving a done pulse after a loaded count
// Assumes: load and count synchronous to the clock
// Notes: count of zero finishes on the next edge
`timescale 1ns/1ps
`default_nettype none
module cycle_timer #(
    parameter int WIDTH = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_count,
    output logic o_done
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic run;
        logic done;
    } timer_t;
    timer_t r;
    timer_t next_r;
    // load wins over counting
    always_comb
    begin
        next_r = r;
        next_r.done = 1'b0;
        if (i_load)
        begin
            next_r.cnt = i_count;
            next_r.run = 1'b1;
        end
        else if (r.run)
        begin
            if (r.cnt == '0)
            begin
                next_r.run = 1'b0;
                next_r.done = 1'b1;
            end
            else
            begin
                next_r.cnt = r.cnt - 1'b1;
            end
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            r <= '0;
        else
            r <= next_r;
    end
    assign o_done = r.done;
endmodule
`default_nettype wire

// File: design/sram_host_ctrl.sv
// Purpose: host controller driving an asynchronous edac sram by its pins
// Assumes: pin inputs synchronous to i_sys_clk; external pull-down on flag
// Notes: one access at a time; flag error starts the clearing sequence
// Functional notes
// - read data driven only with output enable low; host asserts it to read
// - selected, enable and strobe high with flag high is edac access; avoid it
// - flag stays latched until host resets it low
// - host deselects first, only then raises output enable
// - host stays deselected until flag settles low
// - while deselected host moves address to last error-free location
// - reselect with enable high, then enable-controlled read at good address
`timescale 1ns/1ps
`default_nettype none
`include "sram_host_map.svh"
module sram_host_ctrl #(
    parameter int ADDR_W = `ADDR_W,
    parameter int DATA_W = `DATA_W,
    parameter int SETTLE_CYC = `SETTLE_CYC_DEFAULT,
    parameter int TW = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_req,
    input wire logic i_we,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_err_ack,
    output logic o_busy,
    output logic o_rvalid,
    output logic [DATA_W-1:0] o_rdata,
    output logic o_err,
    output logic [ADDR_W-1:0] o_err_addr,
    output logic o_recovered,
    output logic [ADDR_W-1:0] o_addr,
    output logic o_chip_select_active_low,
    output logic o_chip_select_active_high,
    output logic o_write_strobe_n,
    output logic o_output_drive_enable_n,
    output logic [DATA_W-1:0] o_dq,
    output logic o_dq_oe,
    input wire logic [DATA_W-1:0] i_dq,
    input wire logic i_bit_error_flag
);
    typedef struct packed {
        sram_host_pkg::state_t st;
        logic busy;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic err;
        logic [ADDR_W-1:0] err_addr;
        logic [ADDR_W-1:0] good_addr;
        logic recovered;
        logic [ADDR_W-1:0] addr;
        logic cs_n;
        logic cs;
        logic we_n;
        logic oe_n;
        logic [DATA_W-1:0] dq;
        logic dq_oe;
    } ctrl_t;
    ctrl_t r;
    ctrl_t next_r;
    logic tload;
    logic [TW-1:0] tcount;
    logic tdone;
    // one shared wait timer for access, settle and flag-valid delays
    cycle_timer #(.WIDTH(TW)) u_timer (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_load(tload),
        .i_count(tcount),
        .o_done(tdone)
    );
    // sequencing of the pins; idle is scrub standby with enable high
    always_comb
    begin
        next_r = r;
        tload = 1'b0;
        tcount = '0;
        next_r.rvalid = 1'b0;
        next_r.recovered = 1'b0;
        if (i_err_ack)
            next_r.err = 1'b0;
        unique case (r.st)
            sram_host_pkg::st_idle:
            begin
                next_r.busy = 1'b0;
                next_r.cs_n = 1'b0;
                next_r.cs = 1'b0;
                next_r.oe_n = 1'b1;
                next_r.we_n = 1'b1;
                next_r.dq_oe = 1'b0;
                if (i_req)
                begin
                    next_r.busy = 1'b1;
                    next_r.addr = i_addr;
                    next_r.cs = 1'b1;
                    tload = 1'b1;
                    tcount = TW'(`ACCESS_CYC);
                    if (i_we)
                    begin
                        // strobe low on the same edge as select keeps edac access out of reach
                        next_r.we_n = 1'b0;
                        next_r.dq = i_wdata;
                        next_r.dq_oe = 1'b1;
                        next_r.st = sram_host_pkg::st_write;
                    end
                    else
                    begin
                        next_r.oe_n = 1'b0;
                        next_r.st = sram_host_pkg::st_read;
                    end
                end
            end
            sram_host_pkg::st_read:
            begin
                if (tdone)
                    next_r.st = sram_host_pkg::st_rsample;
            end
            sram_host_pkg::st_rsample:
            begin
                next_r.rdata = i_dq;
                next_r.rvalid = 1'b1;
                if (i_bit_error_flag)
                begin
                    next_r.err = 1'b1;
                    next_r.err_addr = r.addr;
                    next_r.cs = 1'b0; // deselect while enable still low
                    next_r.st = sram_host_pkg::st_deselect;
                end
                else
                begin
                    next_r.good_addr = r.addr;
                    next_r.cs = 1'b0;
                    next_r.oe_n = 1'b1;
                    next_r.st = sram_host_pkg::st_idle;
                end
            end
            sram_host_pkg::st_write:
            begin
                if (tdone)
                begin
                    // strobe rises and select drops on the same edge, both end together at pins
                    next_r.we_n = 1'b1;
                    next_r.cs = 1'b0;
                    next_r.good_addr = r.addr;
                    next_r.st = sram_host_pkg::st_idle;
                end
            end
            sram_host_pkg::st_deselect:
            begin
                next_r.oe_n = 1'b1;
                next_r.addr = r.good_addr;
                tload = 1'b1;
                tcount = TW'(SETTLE_CYC);
                next_r.st = sram_host_pkg::st_drive_off;
            end
            sram_host_pkg::st_drive_off:
            begin
                next_r.st = sram_host_pkg::st_settle;
            end
            sram_host_pkg::st_settle:
            begin
                if (tdone)
                begin
                    next_r.cs = 1'b1; // reselect, enable high
                    next_r.st = sram_host_pkg::st_reselect;
                end
            end
            sram_host_pkg::st_reselect:
            begin
                next_r.oe_n = 1'b0;
                tload = 1'b1;
                tcount = TW'(`FLAG_VALID_CYC);
                next_r.st = sram_host_pkg::st_recover;
            end
            sram_host_pkg::st_recover:
            begin
                if (tdone)
                    next_r.st = sram_host_pkg::st_done;
            end
            sram_host_pkg::st_done:
            begin
                // flag must read low now; device back in normal read state
                next_r.recovered = !i_bit_error_flag;
                next_r.cs = 1'b0;
                next_r.oe_n = 1'b1;
                next_r.st = sram_host_pkg::st_idle;
            end
            default:
            begin
                next_r.st = sram_host_pkg::st_idle;
            end
        endcase
    end
    // the active-low select is raised only in reset, so scrub keeps running
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            r <= '0;
            r.st <= sram_host_pkg::st_idle;
            r.cs_n <= 1'b1; // standby without scrub in reset
            r.we_n <= 1'b1;
            r.oe_n <= 1'b1;
            r.addr <= `ADDR_ZERO;
            r.dq <= `DATA_ZERO;
        end
        else
        begin
            r <= next_r;
        end
    end
    assign o_busy = r.busy;
    assign o_rvalid = r.rvalid;
    assign o_rdata = r.rdata;
    assign o_err = r.err;
    assign o_err_addr = r.err_addr;
    assign o_recovered = r.recovered;
    assign o_addr = r.addr;
    assign o_chip_select_active_low = r.cs_n;
    assign o_chip_select_active_high = r.cs;
    assign o_write_strobe_n = r.we_n;
    assign o_output_drive_enable_n = r.oe_n;
    assign o_dq = r.dq;
    assign o_dq_oe = r.dq_oe;
endmodule
`default_nettype wire

// File: design/sram_host_map.svh
// Purpose: named constants for the sram host controller
// Assumes: 100 MHz system clock
// Notes: times in ns, flag valid in tenths of ns; access and flag-valid cycle counts derived from them
`ifndef SRAM_HOST_MAP_SVH
`define SRAM_HOST_MAP_SVH
`define SYS_CLK_PERIOD_NS 10
`define FLAG_VALID_NS 86
`define FLAG_VALID_DIV 10
// least time rounds up: 8.6 ns -> cycles
`define FLAG_VALID_CYC ((`FLAG_VALID_NS + `FLAG_VALID_DIV * `SYS_CLK_PERIOD_NS - 1) \
    / (`FLAG_VALID_DIV * `SYS_CLK_PERIOD_NS))
`define ACCESS_NS 20
`define ACCESS_CYC ((`ACCESS_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define SETTLE_CYC_DEFAULT 8
`define ADDR_W 19
`define DATA_W 32
`define ADDR_ZERO 19'h00000
`define DATA_ZERO 32'h00000000
`endif

// File: design/sram_host_pkg.sv
// Purpose: types for the sram host controller
// Assumes: nothing
// Notes: gray codes on every step but the exits of rsample and done
package sram_host_pkg;
    typedef enum logic [3:0] {
        st_idle = 4'h0,
        st_read = 4'h1,
        st_rsample = 4'h3,
        st_write = 4'h2,
        st_deselect = 4'h6,
        st_drive_off = 4'h7,
        st_settle = 4'h5,
        st_reselect = 4'h4,
        st_recover = 4'hc,
        st_done = 4'hd
    } state_t;
endpackage
